// ===== measurement_mux_sequencer.sv
// Functional notes
// RULE_01: step pulses advance a fixed built-in ordering
// RULE_02: stand-alone: eight steps, bus then current
// RULE_03: schedule repeats until timeout or disable
// RULE_04: controller sends an initial pulse first
// RULE_05: regular stepping only after 14.75-24.25 us gap
// RULE_06: static step input too long: standby, hi-z
// RULE_07: paired: twelve steps, halves per device
// RULE_08: partner's steps leave our output hi-z
// RULE_09: floating role input means stand-alone
// RULE_10: bus valid low until supply and buses good; the code checks the buses only while bypass is high
// RULE_11: bypass high keeps flag low without supply
// RULE_12: power-state high opens divider ground switch
// RULE_13: power-state held low during supply ramp
// RULE_14: idle timeout at least 35 us
// RULE_15: controller keeps step period 0.185-11 us
// RULE_16: floating power-state: step reset, hi-z, switch closed
// RULE_17: role low is first device, high second
// RULE_18: advance on rising edges, step one first
`timescale 1ns/1ps

module sel_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : bad_params
      $error("sel_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_type;

  fifo_state_type r;
  fifo_state_type n;
  logic push;
  logic pop;

  assign in_ready = (r.count != (AW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rd];

  always_comb
  begin
    n = r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push)
    begin
      n.mem[r.wr] = in_data;
      n.wr = r.wr + 1'b1;
    end
    if (pop)
    begin
      n.rd = r.rd + 1'b1;
    end
    if (push && !pop)
    begin
      n.count = r.count + 1'b1;
    end
    else if (pop && !push)
    begin
      n.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end
endmodule : sel_fifo

module measurement_mux_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic step_select_input,
  input wire logic [NUM_CH-1:0] bus_sense_input,
  input wire logic supply_valid,
  input wire logic bypass_input,
  input wire logic power_state_high,
  input wire logic power_state_float,
  input wire logic pair_role_high,
  input wire logic pair_role_float,
  output logic analog_out_pos_oe_n,
  output logic analog_out_neg_oe_n,
  output logic [CH_W-1:0] sel_channel,
  output logic sel_is_current,
  output logic [STEP_W-1:0] sel_step,
  output logic bus_valid_flag_out,
  output logic bus_valid_flag_oe_n,
  output logic divider_ground_switch_out,
  output logic divider_ground_switch_oe_n,
  output logic seq_running,
  output logic step_dropped
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] filt;
    logic step_prev;
    seq_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [STEP_W-1:0] step;
    logic pend_valid;
    sel_word_type pend_word;
    sel_word_type hold_word;
    logic busy;
    logic req;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic bus_ok_oe_n;
    logic gnd_oe_n;
    logic running;
    logic dropped;
  } sys_state_type;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack;
    logic oe_n;
    logic [CH_W-1:0] channel;
    logic is_current;
    logic [STEP_W-1:0] step;
  } link_state_type;

  sys_state_type r;
  sys_state_type n;
  link_state_type lr;
  link_state_type ln;

  logic fifo_in_ready;
  logic fifo_out_valid;
  sel_word_type fifo_out_word;

  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] agree;
  logic step_lvl;
  logic rise;
  logic fall;
  logic full_func;
  logic paired;
  logic timed_out;
  logic push;
  sel_word_type push_word;
  logic [STEP_W-1:0] last_step;
  logic bus_ok;

  assign pins = {pair_role_float, pair_role_high, power_state_float, power_state_high,
                 bypass_input, supply_valid, bus_sense_input, step_select_input};

  // one schedule entry from the step index and the pair role
  function automatic sel_word_type make_word(input logic [STEP_W-1:0] step, input logic pair,
                                             input logic role_b, input logic run);
    sel_word_type w;
    logic a_half;
    logic [STEP_W-1:0] j;
    a_half = (step < PAIR_HALF);
    j = (pair && !a_half) ? step - PAIR_HALF : step;
    w.step = step;
    w.channel = j[CH_W:1]; // RULE_02
    w.is_current = j[0]; // RULE_02
    w.drive = run && (pair ? (role_b ^ a_half) : 1'b1); // RULE_08 RULE_17
    return w;
  endfunction : make_word

  sel_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(sys_rst),
    .in_valid(r.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(r.pend_word),
    .out_valid(fifo_out_valid),
    .out_ready(!r.busy),
    .out_data(fifo_out_word)
  );

  always_comb
  begin
    n = r;
    push = 1'b0;
    push_word = '0;

    // pins: three stages, a change counts once stages two and three agree
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    agree = ~(r.s2 ^ r.s3);
    n.filt = (agree & r.s3) | (~agree & r.filt);

    step_lvl = r.filt[PIN_STEP];
    rise = step_lvl && !r.step_prev; // RULE_18
    fall = !step_lvl && r.step_prev;
    n.step_prev = step_lvl;
    full_func = !r.filt[PIN_PWR_FLOAT] && !r.filt[PIN_PWR_HIGH];
    paired = !r.filt[PIN_ROLE_FLOAT]; // RULE_09
    last_step = paired ? STEP_LAST_PAIR : STEP_LAST_SOLO; // RULE_07

    // cycles since the last edge of the step input, saturating
    if (rise || fall)
    begin
      n.cnt = CNT_ZERO;
    end
    else if (r.cnt != '1)
    begin
      n.cnt = r.cnt + 1'b1;
    end
    timed_out = (r.cnt >= IDLE_TIMEOUT_CYC); // RULE_14

    unique case (r.state)
      ST_STANDBY:
      begin
        if (rise)
        begin
          n.state = ST_INIT_HIGH; // RULE_04
        end
      end
      ST_INIT_HIGH:
      begin
        if (fall)
        begin
          n.state = ST_GAP;
        end
        else if (timed_out)
        begin
          n.state = ST_STANDBY; // RULE_06
        end
      end
      ST_GAP:
      begin
        if (rise)
        begin
          // a rise outside the window is taken as another initial pulse
          if (r.cnt >= GAP_MIN_CYC && r.cnt <= GAP_MAX_CYC) // RULE_05
          begin
            n.state = ST_RUN;
            n.step = STEP_FIRST; // RULE_18
            push = 1'b1;
            push_word = make_word(STEP_FIRST, paired, r.filt[PIN_ROLE_HIGH], 1'b1);
          end
          else
          begin
            n.state = ST_INIT_HIGH;
          end
        end
        else if (timed_out)
        begin
          n.state = ST_STANDBY; // RULE_06
        end
      end
      ST_RUN:
      begin
        if (timed_out)
        begin
          n.state = ST_STANDBY; // RULE_03 RULE_06
          push = 1'b1;
          push_word = make_word(r.step, paired, r.filt[PIN_ROLE_HIGH], 1'b0);
        end
        else if (rise)
        begin
          n.step = (r.step >= last_step) ? STEP_FIRST : r.step + 1'b1; // RULE_01 RULE_02 RULE_07
          push = 1'b1;
          push_word = make_word(n.step, paired, r.filt[PIN_ROLE_HIGH], 1'b1);
        end
      end
    endcase

    // limited function or standby holds the step logic in reset
    if (!full_func)
    begin
      n.state = ST_STANDBY; // RULE_16 RULE_03
      n.step = STEP_FIRST;
      push = (r.state == ST_RUN);
      push_word = make_word(r.step, paired, r.filt[PIN_ROLE_HIGH], 1'b0);
    end

    // one-entry holding stage ahead of the fifo; a newer word replaces a stalled one
    if (r.pend_valid && fifo_in_ready)
    begin
      n.pend_valid = 1'b0;
    end
    if (push)
    begin
      n.pend_valid = 1'b1;
      n.pend_word = push_word;
    end
    n.dropped = push && r.pend_valid && !fifo_in_ready;

    // word handshake towards the link domain
    n.ack_s1 = lr.ack;
    n.ack_s2 = r.ack_s1;
    n.ack_s3 = r.ack_s2;
    if (r.busy && (r.ack_s2 != r.ack_s3))
    begin
      n.busy = 1'b0;
    end
    else if (!r.busy && fifo_out_valid)
    begin
      n.hold_word = fifo_out_word;
      n.req = !r.req;
      n.busy = 1'b1;
    end

    // open-drain flag: released only when every condition holds
    bus_ok = r.filt[PIN_SUPPLY] && !r.filt[PIN_PWR_HIGH]
             && (!r.filt[PIN_BYPASS] || (&r.filt[PIN_SENSE_LO +: NUM_CH])); // RULE_10 RULE_11
    n.bus_ok_oe_n = bus_ok; // RULE_10
    n.gnd_oe_n = r.filt[PIN_PWR_HIGH]; // RULE_12 RULE_16
    n.running = (n.state == ST_RUN);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  // link side: hold_word is stable while busy, so it is sampled after the toggle settles
  always_comb
  begin
    ln = lr;
    ln.req_s1 = r.req;
    ln.req_s2 = lr.req_s1;
    ln.req_s3 = lr.req_s2;
    if (lr.req_s2 != lr.req_s3)
    begin
      ln.ack = !lr.ack;
      ln.oe_n = !r.hold_word.drive; // RULE_08 RULE_06
      ln.channel = r.hold_word.channel;
      ln.is_current = r.hold_word.is_current;
      ln.step = r.hold_word.step;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lr <= '0;
      lr.oe_n <= 1'b1;
    end
    else
    begin
      lr <= ln;
    end
  end

  assign analog_out_pos_oe_n = lr.oe_n;
  assign analog_out_neg_oe_n = lr.oe_n;
  assign sel_channel = lr.channel;
  assign sel_is_current = lr.is_current;
  assign sel_step = lr.step;
  assign bus_valid_flag_out = r.step_prev & 1'b0;
  assign bus_valid_flag_oe_n = r.bus_ok_oe_n;
  assign divider_ground_switch_out = r.step_prev & 1'b0;
  assign divider_ground_switch_oe_n = r.gnd_oe_n;
  assign seq_running = r.running;
  assign step_dropped = r.dropped;

endmodule : measurement_mux_sequencer

// ===== seq_pkg.sv
package seq_pkg;

  // timing, all in ns, then in sys_clk cycles
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned IDLE_TIMEOUT_NS = 35000;
  localparam int unsigned GAP_MIN_NS = 14750;
  localparam int unsigned GAP_MAX_NS = 24250;
  // least times round up, longest times round down
  localparam int unsigned IDLE_TIMEOUT_CYC_I = (IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_MIN_CYC_I = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_MAX_CYC_I = GAP_MAX_NS / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 11;
  localparam logic [CNT_W-1:0] IDLE_TIMEOUT_CYC = CNT_W'(IDLE_TIMEOUT_CYC_I);
  localparam logic [CNT_W-1:0] GAP_MIN_CYC = CNT_W'(GAP_MIN_CYC_I);
  localparam logic [CNT_W-1:0] GAP_MAX_CYC = CNT_W'(GAP_MAX_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

  // schedule
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned STEP_W = 4;
  localparam int unsigned CH_W = 2;
  localparam logic [STEP_W-1:0] STEP_FIRST = 4'h0;
  localparam logic [STEP_W-1:0] STEP_LAST_SOLO = 4'h7;
  localparam logic [STEP_W-1:0] STEP_LAST_PAIR = 4'hB;
  localparam logic [STEP_W-1:0] PAIR_HALF = 4'h6;

  // synchronised pin vector layout
  localparam int unsigned PIN_STEP = 0;
  localparam int unsigned PIN_SENSE_LO = 1;
  localparam int unsigned PIN_SUPPLY = PIN_SENSE_LO + NUM_CH;
  localparam int unsigned PIN_BYPASS = PIN_SUPPLY + 1;
  localparam int unsigned PIN_PWR_HIGH = PIN_BYPASS + 1;
  localparam int unsigned PIN_PWR_FLOAT = PIN_PWR_HIGH + 1;
  localparam int unsigned PIN_ROLE_HIGH = PIN_PWR_FLOAT + 1;
  localparam int unsigned PIN_ROLE_FLOAT = PIN_ROLE_HIGH + 1;
  localparam int unsigned PIN_COUNT = PIN_ROLE_FLOAT + 1;

  localparam int unsigned FIFO_DEPTH = 4;

  typedef enum logic [1:0] {ST_STANDBY, ST_INIT_HIGH, ST_GAP, ST_RUN} seq_state_type;

  typedef struct packed {
    logic drive;
    logic is_current;
    logic [CH_W-1:0] channel;
    logic [STEP_W-1:0] step;
  } sel_word_type;

  localparam int unsigned WORD_W = $bits(sel_word_type);

endpackage : seq_pkg

// ===== step_ctrl.sv
`timescale 1ns/1ps
module step_ctrl
(
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] gap,
  input wire logic [15:0] half,
  input wire logic [15:0] n,
  output logic step_pin
);
  initial step_pin = 1'b0;

  // pin is actively driven low between frames, so no float is modelled
  always @(posedge go)
  begin
    @(posedge clk);
    #1 step_pin = 1'b1;
    repeat (50) @(posedge clk);
    #1 step_pin = 1'b0;
    repeat (gap) @(posedge clk);
    repeat (n)
    begin
      #1 step_pin = 1'b1;
      repeat (half) @(posedge clk);
      #1 step_pin = 1'b0;
      repeat (half) @(posedge clk);
    end
  end
endmodule : step_ctrl

// ===== measurement_mux_sequencer_monitor.sv
`timescale 1ns/1ps
module mux_seq_monitor
  import seq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic step_select_input,
  input wire logic [NUM_CH-1:0] bus_sense_input,
  input wire logic supply_valid,
  input wire logic bypass_input,
  input wire logic power_state_high,
  input wire logic power_state_float,
  input wire logic pair_role_high,
  input wire logic pair_role_float,
  input wire logic analog_out_pos_oe_n,
  input wire logic analog_out_neg_oe_n,
  input wire logic [CH_W-1:0] sel_channel,
  input wire logic [STEP_W-1:0] sel_step,
  input wire logic bus_valid_flag_oe_n,
  input wire logic divider_ground_switch_oe_n,
  input wire logic seq_running
);
  logic pin_r;
  logic [11:0] idle_cnt;
  wire bv_ok = supply_valid & ~power_state_high & (~bypass_input | (&bus_sense_input));
  wire drv = ~analog_out_pos_oe_n;

  // counts raw pin, so it runs a few cycles ahead of the synced design count
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      pin_r <= 1'b0;
      idle_cnt <= 12'h000;
    end
    else
    begin
      pin_r <= step_select_input;
      if (pin_r != step_select_input)
        idle_cnt <= 12'h000;
      else if (idle_cnt != 12'hFFF)
        idle_cnt <= idle_cnt + 12'h001;
    end

  sequence bv_good_s;
    bv_ok [*7];
  endsequence
  sequence pwr_off_s;
    (power_state_high | power_state_float) [*7];
  endsequence

  bv_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bv_good_s |-> bus_valid_flag_oe_n) else $error("flag not released");
  bv_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!bv_ok) [*7] |-> !bus_valid_flag_oe_n) else $error("flag not held low");
  gnd_open_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    power_state_high [*7] |-> divider_ground_switch_oe_n) else $error("switch not open");
  gnd_closed_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!power_state_high) [*7] |-> !divider_ground_switch_oe_n) else $error("switch not closed");
  pwr_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pwr_off_s |-> !seq_running) else $error("stepping while disabled");
  timeout_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    idle_cnt >= 12'h708 |-> !seq_running && analog_out_pos_oe_n) else $error("no standby");
  timeout_early_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(seq_running) && !power_state_high && !power_state_float |-> idle_cnt >= 12'h6CC)
    else $error("timeout too early");
  oe_pair_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    !pair_role_float && !pair_role_high && sel_step >= 4'h6 |-> analog_out_pos_oe_n && analog_out_neg_oe_n)
    else $error("first device drives partner step");
  solo_map_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    drv && pair_role_float |-> sel_step <= 4'h7 && sel_channel == sel_step[2:1])
    else $error("solo step map");
  pair_half_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    drv && !pair_role_float |-> (pair_role_high ? sel_step >= 4'h6 : sel_step < 4'h6) && sel_step <= 4'hB)
    else $error("drives partner step");
endmodule : mux_seq_monitor

bind measurement_mux_sequencer mux_seq_monitor mon_u (.*);

// ===== measurement_mux_sequencer_tb_top.sv
`timescale 1ns/1ps
module measurement_mux_sequencer_tb_top
  import seq_pkg::*;
;
  logic sys_clk, sys_rst, link_clk, step_select_input, supply_valid, bypass_input, go;
  logic power_state_high, power_state_float, pair_role_high, pair_role_float, seq_running;
  logic analog_out_pos_oe_n, analog_out_neg_oe_n, sel_is_current, bus_valid_flag_oe_n;
  logic divider_ground_switch_oe_n, bus_valid_flag_out, divider_ground_switch_out, step_dropped, drop_seen;
  logic [NUM_CH-1:0] bus_sense_input;
  logic [CH_W-1:0] sel_channel;
  logic [STEP_W-1:0] sel_step;
  logic [15:0] gap, half, n;
  int failures, checked;
  // supply, bypass, high, float, sense, flag released, switch open
  logic [9:0] rows [6] = '{10'h202, 10'h33E, 10'h31C, 10'h13C, 10'h281, 10'h242};

  measurement_mux_sequencer dut_u (.*);
  step_ctrl ctrl_u (.clk(sys_clk), .go(go), .gap(gap), .half(half), .n(n), .step_pin(step_select_input));

  always #10 sys_clk = ~sys_clk;
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  // the overflow flag lasts one cycle, so it is kept until the check
  always @(posedge sys_clk)
  begin
    if (sys_rst)
      drop_seen <= 1'b0;
    else if (step_dropped === 1'b1)
      drop_seen <= 1'b1;
  end

  task bad(input string m);
    failures++;
    $display("wrong value at %0t: %s", $time, m);
  endtask : bad

  task test_done;
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task run(input int gp, input int hf, input int num, input logic pf, input logic ph, input logic good);
    int s;
    logic drv;
    pair_role_float = pf;
    pair_role_high = ph;
    gap = 16'(gp);
    half = 16'(hf);
    n = 16'(num);
    go = 1'b1;
    @(posedge step_select_input);
    go = 1'b0;
    for (int i = 0; i < num; i++)
    begin
      @(posedge step_select_input);
      repeat (60) @(posedge sys_clk);
      #1 s = pf ? i % 8 : i % 12;
      drv = pf || (ph ? s >= 6 : s < 6);
      checked++;
      if (!good && seq_running !== 1'b0) bad("step accepted after bad gap");
      if (good && analog_out_pos_oe_n !== !drv) bad("output enable");
      if (good && drv && {sel_step, sel_channel, sel_is_current} !== {4'(s), 2'((pf ? s : s % 6) >> 1), s[0]})
        bad("step selection");
    end
    repeat (2 * hf + 1800) @(posedge sys_clk);
    #1 checked++;
    if (seq_running !== 1'b0 || analog_out_pos_oe_n !== 1'b1) bad("no standby after idle");
  endtask : run

  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    go = 1'b0;
    {gap, half, n} = '0;
    bus_sense_input = 4'hF;
    supply_valid = 1'b1;
    bypass_input = 1'b0;
    power_state_high = 1'b0;
    power_state_float = 1'b0;
    pair_role_high = 1'b0;
    pair_role_float = 1'b1;
    repeat (5) @(posedge sys_clk);
    checked++;
    if ({analog_out_pos_oe_n, analog_out_neg_oe_n, bus_valid_flag_oe_n, divider_ground_switch_oe_n} !== 4'hC)
      bad("reset levels");
    if ({seq_running, step_dropped, bus_valid_flag_out, divider_ground_switch_out, sel_step} !== 8'h00)
      bad("reset outputs");
    #1 sys_rst = 1'b0;
    foreach (rows[i])
    begin
      {supply_valid, bypass_input, power_state_high, power_state_float, bus_sense_input} = rows[i][9:2];
      repeat (8) @(posedge sys_clk);
      #1 checked++;
      if ({bus_valid_flag_oe_n, divider_ground_switch_oe_n} !== rows[i][1:0])
        bad("flag or switch level");
    end
    power_state_float = 1'b0;
    #200;
    run(800, 100, 9, 1'b1, 1'b0, 1'b1);
    run(800, 250, 13, 1'b0, 1'b0, 1'b1);
    run(800, 250, 13, 1'b0, 1'b1, 1'b1);
    run(300, 100, 3, 1'b1, 1'b0, 1'b0);
    run(1300, 100, 3, 1'b1, 1'b0, 1'b0);
    // steps at the fastest legal rate outrun the link handshake, so the holding stage overflows
    {gap, half, n} = {16'h0320, 16'h0005, 16'h0018};
    go = 1'b1;
    @(posedge step_select_input);
    go = 1'b0;
    repeat (3000) @(posedge sys_clk);
    #1 checked++;
    if (drop_seen !== 1'b1) bad("no overflow pulse");
    if (seq_running !== 1'b0 || analog_out_pos_oe_n !== 1'b1) bad("no standby after burst");
    test_done();
  end

  initial
  begin
    #1000000;
    failures++;
    test_done();
  end
endmodule : measurement_mux_sequencer_tb_top
